/* File: core/gppr_top.sv */
// gppr_top: output timing and power regulation for four glow-plug gate drivers
// assumes pins synchronous to core_clk; straps stable; failure inputs already filtered
`default_nettype none
module gppr_top
	import gppr_pkg::*;
(
	input wire logic core_clk, // 25 mhz clock
	input wire logic rst_n, // async reset, active low
	input wire logic pwm_command_input, // command pwm from engine controller
	input wire logic [7:0] battery_voltage, // battery voltage code, decivolts
	input wire logic [2:0] mode_sel, // base mode strap, 1..6
	input wire logic reg_disable_pin, // mode pin level: high when tied to current_set_pin
	input wire logic [3:0] fail_raw, // per-output failure detect
	output logic [3:0] gate_drive_outputs, // gate pwm outputs
	output logic [3:0] fail_valid, // failures outside blanking, registered
	output logic regulating // regulation active, decoded from registered straps
);
	gppr_mode_t mode_ff;
	logic strap_done_ff;
	logic ci_d_ff;
	logic [23:0] ci_cnt_ff, ci_on_ff, ci_per_ff;
	logic [9:0] cmd_duty_ff;
	logic calc_start_ff;
	logic [9:0] out_duty;
	logic out_done;
	gppr_state_t st_ff, nxt_st;
	logic [1:0] ch_ff, nxt_ch;
	logic [23:0] tmr_ff, nxt_tmr;
	logic [23:0] on_len_ff, per_len_ff;
	logic [3:0] gate_ff;
	logic [23:0] blank_ff [GPPR_NUM_OUT];
	logic [3:0] fail_ff;
	logic reg_ff;
	logic ci_rise, ci_fall;
	logic transistor_mode, mode_reg;
	logic [33:0] duty_prod;
	logic [23:0] on_from_duty;
	logic [23:0] slot_len;
	logic [3:0] sw_event;

	// straps are caught once after reset release, never inside the async reset branch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= GPPR_MODE_TR_SHUNT_NOREG;
			reg_ff <= 1'b0;
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			mode_ff <= gppr_mode_t'(mode_sel);
			reg_ff <= !reg_disable_pin;
			strap_done_ff <= 1'b1;
		end
	end
	// modes 3 and 5 never regulate; 4 and 6 only when the mode pin reads low
	assign transistor_mode = mode_ff inside {GPPR_MODE_TR_SHUNT_NOREG, GPPR_MODE_TR_SHUNT_REG,
		GPPR_MODE_TR_FET_NOREG, GPPR_MODE_TR_FET_REG};
	assign mode_reg = (mode_ff == GPPR_MODE_TR_SHUNT_REG || mode_ff == GPPR_MODE_TR_FET_REG)
		&& reg_ff;
	assign regulating = mode_reg && strap_done_ff;

	// command input duty measured rising edge to rising edge
	assign ci_rise = pwm_command_input && !ci_d_ff;
	assign ci_fall = !pwm_command_input && ci_d_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ci_d_ff <= 1'b0;
			ci_cnt_ff <= 24'h0;
			ci_on_ff <= 24'h0;
			ci_per_ff <= 24'h0;
			calc_start_ff <= 1'b0;
		end else begin
			ci_d_ff <= pwm_command_input;
			ci_cnt_ff <= ci_rise ? 24'h1 : ci_cnt_ff + 24'h1;
			if (ci_fall) begin
				ci_on_ff <= ci_cnt_ff;
			end
			if (ci_rise) begin
				ci_per_ff <= ci_cnt_ff;
			end
			calc_start_ff <= ci_rise;
		end
	end
	// one-shot per-period divide; a divider per period is cheap next to the 10 ms period
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_duty_ff <= 10'h0;
		end else if (ci_rise && ci_cnt_ff != 24'h0) begin
			cmd_duty_ff <= 10'((34'(ci_on_ff) * 34'(GPPR_DUTY_FULL)) / 34'(ci_cnt_ff));
		end
	end

	gppr_scale u_scale (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(calc_start_ff),
		.regulate(regulating),
		.duty_in(cmd_duty_ff),
		.battery_voltage(battery_voltage),
		.duty_out(out_duty),
		.done(out_done)
	);

	// high time scales with duty; in transistor modes the period stretches by one gap per slot
	assign duty_prod = 34'(GPPR_TG_NOM_CYC) * 34'(out_duty);
	assign on_from_duty = 24'(duty_prod / 34'(GPPR_DUTY_FULL));
	assign slot_len = per_len_ff >> 2;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_len_ff <= 24'h0;
			per_len_ff <= GPPR_TG_NOM_CYC;
		end else if (out_done) begin
			on_len_ff <= on_from_duty >> 2; // each plug takes a quarter of the period in turn
			per_len_ff <= GPPR_TG_NOM_CYC + (transistor_mode ? GPPR_TGAP_CYC << 2 : 24'h0);
		end
	end

	// sequencer: plugs fire one after another; gap only in transistor modes
	always_comb begin
		nxt_st = st_ff;
		nxt_ch = ch_ff;
		nxt_tmr = tmr_ff + 24'h1;
		unique case (st_ff)
			GPPR_ST_IDLE: begin
				nxt_tmr = 24'h0;
				if (on_len_ff != 24'h0) begin
					nxt_st = GPPR_ST_ON;
				end
			end
			GPPR_ST_ON: begin
				if (tmr_ff + 24'h1 >= on_len_ff) begin
					nxt_st = GPPR_ST_GAP;
				end
			end
			GPPR_ST_GAP: begin
				if (tmr_ff + 24'h1 >= slot_len && (!transistor_mode ||
					tmr_ff + 24'h1 >= on_len_ff + GPPR_TGAP_CYC)) begin
					nxt_st = (on_len_ff != 24'h0) ? GPPR_ST_ON : GPPR_ST_IDLE;
					nxt_ch = ch_ff + 2'h1;
					nxt_tmr = 24'h0;
				end
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= GPPR_ST_IDLE;
			ch_ff <= 2'h0;
			tmr_ff <= 24'h0;
			gate_ff <= 4'h0;
		end else begin
			st_ff <= nxt_st;
			ch_ff <= nxt_ch;
			tmr_ff <= nxt_tmr;
			gate_ff <= (nxt_st == GPPR_ST_ON) ? (4'h1 << nxt_ch) : 4'h0;
		end
	end
	assign gate_drive_outputs = gate_ff;
	assign sw_event = gate_ff ^ ((nxt_st == GPPR_ST_ON) ? (4'h1 << nxt_ch) : 4'h0);

	// per-output blanking: failures during the switching slope are never recorded
	genvar gi;
	generate
		for (gi = 0; gi < GPPR_NUM_OUT; gi++) begin : g_blank
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					blank_ff[gi] <= 24'h0;
					fail_ff[gi] <= 1'b0;
				end else begin
					if (sw_event[gi]) begin
						blank_ff[gi] <= GPPR_TSUP_CYC;
					end else if (blank_ff[gi] != 24'h0) begin
						blank_ff[gi] <= blank_ff[gi] - 24'h1;
					end
					fail_ff[gi] <= fail_raw[gi] && blank_ff[gi] == 24'h0 && !sw_event[gi];
				end
			end
		end
	endgenerate
	assign fail_valid = fail_ff;
endmodule
`default_nettype wire

/* File: core/gppr_pkg.sv */
// gppr_pkg: constants and types shared by the glow-plug pwm power regulator
// assumes a 25 mhz core clock; battery voltage arrives as an unsigned code in 0.1 v steps
`default_nettype none
package gppr_pkg;
	localparam int unsigned GPPR_CLK_HZ = 25000000;
	localparam int unsigned GPPR_NUM_OUT = 4;
	// duty values are fractions of GPPR_DUTY_FULL
	localparam int unsigned GPPR_DUTY_W = 10;
	localparam logic [9:0] GPPR_DUTY_FULL = 10'h3ff;
	// battery voltage code in decivolts
	localparam int unsigned GPPR_VBAT_W = 8;
	localparam logic [7:0] GPPR_VBAT_NOM = 8'h78; // 12.0 v nominal
	localparam logic [7:0] GPPR_VBAT_MIN = 8'h1e; // below 3.0 v treat reading as invalid
	// command input period measurement
	localparam int unsigned GPPR_CNT_W = 24;
	// nominal output period, gap and slope blanking times
	localparam int unsigned GPPR_TG_NOM_US = 10000;
	localparam int unsigned GPPR_TGAP_US = 20;
	localparam int unsigned GPPR_TSUP_US = 50;
	localparam int unsigned GPPR_CYC_PER_US = GPPR_CLK_HZ / 1000000;
	localparam logic [23:0] GPPR_TG_NOM_CYC = 24'(GPPR_TG_NOM_US * GPPR_CYC_PER_US);
	localparam logic [23:0] GPPR_TGAP_CYC = 24'(GPPR_TGAP_US * GPPR_CYC_PER_US);
	localparam logic [23:0] GPPR_TSUP_CYC = 24'(GPPR_TSUP_US * GPPR_CYC_PER_US);
	// operating modes selected by strap pins
	typedef enum logic [2:0] {
		GPPR_MODE_RELAY_GNG = 3'h1,
		GPPR_MODE_RELAY_SER = 3'h2,
		GPPR_MODE_TR_SHUNT_NOREG = 3'h3,
		GPPR_MODE_TR_SHUNT_REG = 3'h4,
		GPPR_MODE_TR_FET_NOREG = 3'h5,
		GPPR_MODE_TR_FET_REG = 3'h6
	} gppr_mode_t;
	typedef enum {GPPR_ST_IDLE, GPPR_ST_ON, GPPR_ST_GAP} gppr_state_t;
endpackage
`default_nettype wire

/* File: core/gppr_scale.sv */
// gppr_scale: computes the regulated output duty from command duty and battery voltage
// assumes inputs stable for the few cycles of a sequential divide; result is registered
`default_nettype none
module gppr_scale
	import gppr_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic start, // pulse: begin a new computation
	input wire logic regulate, // high: apply battery scaling
	input wire logic [9:0] duty_in, // command duty
	input wire logic [7:0] battery_voltage, // decivolt code
	output logic [9:0] duty_out, // scaled duty, registered
	output logic done // pulse: duty_out updated
);
	logic [31:0] num_ff, nxt_num;
	logic [31:0] den_ff, nxt_den;
	logic [31:0] quo_ff, nxt_quo;
	logic [5:0] bit_ff, nxt_bit;
	logic busy_ff, nxt_busy;
	logic [9:0] duty_ff;
	logic done_ff;
	logic [31:0] trial;
	logic [31:0] num_start;
	logic [31:0] den_start;
	logic [9:0] sat_quo;
	logic vbat_ok;

	// duty*12^2/vbat^2, done as one restoring divide so the square never loses precision
	assign vbat_ok = battery_voltage >= GPPR_VBAT_MIN;
	assign num_start = 32'(duty_in) * 32'(GPPR_VBAT_NOM) * 32'(GPPR_VBAT_NOM);
	assign den_start = 32'(battery_voltage) * 32'(battery_voltage);
	assign trial = (num_ff >> bit_ff);
	// saturate the quotient as it finishes, so low battery never asks for more than full on-time
	assign sat_quo = (nxt_quo > 32'(GPPR_DUTY_FULL)) ? GPPR_DUTY_FULL : nxt_quo[9:0];
	always_comb begin
		nxt_num = num_ff;
		nxt_den = den_ff;
		nxt_quo = quo_ff;
		nxt_bit = bit_ff;
		nxt_busy = busy_ff;
		if (start) begin
			nxt_num = num_start;
			nxt_den = den_start;
			nxt_quo = 32'h0;
			nxt_bit = 6'h1f;
			nxt_busy = regulate && vbat_ok;
		end else if (busy_ff) begin
			if (trial >= den_ff) begin
				nxt_num = num_ff - (den_ff << bit_ff);
				nxt_quo = quo_ff | (32'h1 << bit_ff);
			end
			nxt_bit = bit_ff - 6'h1;
			if (bit_ff == 6'h0) begin
				nxt_busy = 1'b0;
			end
		end
	end
	// high-order trial bits that overflow are harmless: such quotients saturate anyway
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			num_ff <= 32'h0;
			den_ff <= 32'h1;
			quo_ff <= 32'h0;
			bit_ff <= 6'h0;
			busy_ff <= 1'b0;
		end else begin
			num_ff <= nxt_num;
			den_ff <= nxt_den;
			quo_ff <= nxt_quo;
			bit_ff <= nxt_bit;
			busy_ff <= nxt_busy;
		end
	end
	// result register: unregulated path passes the command duty through directly
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_ff <= 10'h0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start && !(regulate && vbat_ok)) begin
				duty_ff <= duty_in;
				done_ff <= 1'b1;
			end else if (busy_ff && bit_ff == 6'h0) begin
				duty_ff <= sat_quo;
				done_ff <= 1'b1;
			end
		end
	end
	assign duty_out = duty_ff;
	assign done = done_ff;
endmodule
`default_nettype wire

/* File: verif/gppr_top_monitor.sv */
// gppr_top_monitor: port checks of gate timing, failure blanking and regulation flag
// assumes straps change only while reset is held
`default_nettype none
module gppr_top_monitor
	import gppr_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic rst_n, // async reset, active low
	input wire logic pwm_command_input, // command pwm
	input wire logic [7:0] battery_voltage, // decivolts
	input wire logic [2:0] mode_sel, // mode strap
	input wire logic reg_disable_pin, // regulation off strap
	input wire logic [3:0] fail_raw, // raw failures
	input wire logic [3:0] gate_drive_outputs, // gates
	input wire logic [3:0] fail_valid, // reported failures
	input wire logic regulating // regulation flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [3:0] prev_ff;
	logic [10:0] idle_ff;
	logic [10:0] blk_ff [4];
	logic [1:0] up_ff;
	// transistor modes keep a gap; relay modes do not
	wire tr = mode_sel >= 3'h3;
	wire want = (mode_sel == 3'h4 || mode_sel == 3'h6) && !reg_disable_pin;
	// saturating ages: idle time, time since each gate edge, time since reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 4'h0;
			idle_ff <= 11'h7ff;
			up_ff <= 2'h0;
			for (int i = 0; i < 4; i++) blk_ff[i] <= 11'h7ff;
		end else begin
			prev_ff <= gate_drive_outputs;
			idle_ff <= (gate_drive_outputs != 4'h0) ? 11'h0 : idle_ff + 11'(idle_ff != 11'h7ff);
			up_ff <= up_ff + 2'(up_ff != 2'h3);
			for (int i = 0; i < 4; i++)
				blk_ff[i] <= (gate_drive_outputs[i] != prev_ff[i]) ? 11'h0 :
					blk_ff[i] + 11'(blk_ff[i] != 11'h7ff);
		end
	end
	sequence s_gate_up;
		prev_ff == 4'h0 ##0 gate_drive_outputs != 4'h0;
	endsequence
	a_gates_onehot: assert property ($onehot0(gate_drive_outputs))
		else $error("two gates on at once");
	a_gap_kept: assert property (s_gate_up |-> !tr || idle_ff >= 11'h1f4)
		else $error("gate gap too short");
	a_reg_flag: assert property (up_ff == 2'h3 |-> regulating == want)
		else $error("regulation flag wrong");
	a_noreg_modes: assert property (mode_sel inside {3'h3, 3'h5} |-> !regulating)
		else $error("regulating in unregulated mode");
	a_fail_cause: assert property ((fail_valid & ~$past(fail_raw)) == 4'h0)
		else $error("failure without cause");
	a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n |-> gate_drive_outputs == 4'h0 && fail_valid == 4'h0 && !regulating)
		else $error("outputs active in reset");
	for (genvar i = 0; i < 4; i++) begin : g_out
		a_blank_mask: assert property (fail_valid[i] |-> blk_ff[i] >= 11'h4e1)
			else $error("failure reported in blanking");
		// a gate edge in the previous cycle opens a new blanking window, so it is excluded
		a_fail_pass: assert property ($past(fail_raw[i]) && blk_ff[i] > 11'h514 &&
			gate_drive_outputs[i] == prev_ff[i] |-> fail_valid[i])
			else $error("failure lost after blanking");
	end
endmodule
bind gppr_top gppr_top_monitor u_gppr_top_monitor (.core_clk, .rst_n, .pwm_command_input,
	.battery_voltage, .mode_sel, .reg_disable_pin, .fail_raw, .gate_drive_outputs,
	.fail_valid, .regulating);
`default_nettype wire

/* File: verif/gppr_fet_model.sv */
// gppr_fet_model: four external high-side switches seen from the gate pins
// assumes the bench raises fault_en to emulate faulty plugs
`default_nettype none
module gppr_fet_model (
	input wire logic [3:0] gate_drive_outputs, // gate drive from the block
	input wire logic fault_en, // bench request: faulty plugs
	output logic [3:0] fail_raw // sensed failure per switch
);
	timeunit 1ns;
	timeprecision 1ps;
	// an overcurrent only shows while the switch conducts, so it starts on the slope
	assign fail_raw = gate_drive_outputs & {4{fault_en}};
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// testbench: drives command pwm and straps, measures gate pulses and failure reports
// assumes the monitor is bound to gppr_top and the fet model closes the failure loop
`default_nettype none
module testbench
	import gppr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic pwm_command_input = 1'b0;
	logic [7:0] battery_voltage = 8'h78;
	logic [2:0] mode_sel = 3'h3;
	logic reg_disable_pin = 1'b0;
	logic fault_en = 1'b0;
	logic [3:0] fail_raw, gate_drive_outputs, fail_valid;
	logic regulating;
	int hi = 10, cnt = 0, n_errors = 0, n_compared = 0;
	gppr_top u_gppr_top (.core_clk, .rst_n, .pwm_command_input, .battery_voltage, .mode_sel,
		.reg_disable_pin, .fail_raw, .gate_drive_outputs, .fail_valid, .regulating);
	gppr_fet_model u_gppr_fet_model (.gate_drive_outputs, .fault_en, .fail_raw);
	always #20 core_clk = ~core_clk;
	// command pwm: high for hi of every 1000 cycles, quiet in reset
	always @(posedge core_clk) begin
		cnt <= (!rst_n || cnt == 999) ? 0 : cnt + 1;
		pwm_command_input <= rst_n && cnt != 0 && cnt <= hi;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// command duty times (12 v / vbat) squared, capped at full slot
	function automatic int exp_len(input int h, input int v, input bit r);
		int d;
		d = h * 1023 / 1000;
		if (r) d = d * 14400 / (v * v);
		if (d > 1023) d = 1023;
		return 62500 * d / 1023;
	endfunction
	// divider rounding in the block is not ours to fix, so allow a small band
	function automatic logic [31:0] near(input int l, input int e);
		return {31'h0, l > e - e / 16 - 3 && l < e + e / 16 + 3};
	endfunction
	task automatic boot(input logic [2:0] m, input logic p, input logic [7:0] v, input int h,
		input logic f);
		@(posedge core_clk);
		rst_n <= 1'b0;
		mode_sel <= m;
		reg_disable_pin <= p;
		battery_voltage <= v;
		hi <= h;
		fault_en <= f;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	// length of the next gate pulse and of the gap after it
	task automatic pulse(input bit chk, output int len, output int gap);
		int w;
		len = 0;
		gap = 0;
		w = 0;
		while (gate_drive_outputs === 4'h0 && w < 99999) begin
			@(negedge core_clk);
			w++;
		end
		while (gate_drive_outputs !== 4'h0 && len < 99999) begin
			@(negedge core_clk);
			len++;
			if (chk && len == 100) check(fail_valid, 4'h0);
			if (chk && len == 1400) check(|fail_valid, 1);
		end
		// the gap is only judged against its lower bound, so a short limit keeps the run brief
		while (gate_drive_outputs === 4'h0 && gap < 999) begin
			@(negedge core_clk);
			gap++;
		end
	endtask
	task automatic s_noreg(input logic [2:0] m, input logic p);
		int len, gap;
		boot(m, p, 8'h3c, 10, 1'b0);
		pulse(1'b0, len, gap);
		check(near(len, exp_len(10, 60, 0)), 1);
		check(gap >= 500, 1);
		check(regulating, 1'b0);
	endtask
	task automatic s_reg;
		int len, gap;
		boot(3'h4, 1'b0, 8'h3c, 10, 1'b1);
		pulse(1'b1, len, gap);
		check(near(len, exp_len(10, 60, 1)), 1);
		check(gap >= 500, 1);
		check(regulating, 1'b1);
	endtask
	task automatic s_sat;
		int len, gap;
		boot(3'h6, 1'b0, 8'h28, 200, 1'b0);
		pulse(1'b0, len, gap);
		check(near(len, 62500), 1);
		check(regulating, 1'b1);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		s_noreg(3'h3, 1'b0);
		s_noreg(3'h5, 1'b0);
		s_noreg(3'h6, 1'b1);
		s_reg;
		s_sat;
		tally_and_finish;
	end
	// watchdog: 95000 cycles, past the roughly 80000 that the scenarios need
	initial begin
		#3800000;
		n_errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
